// ---- verilog/sfs_pkg.sv ----
package sfs_pkg;
    // ****************************************
    // Instruction codes (values arbitrary)
    // ****************************************
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h31;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h32;
    localparam logic [7:0] CMD_STATUS_READ = 8'h33;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h34;
    localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h35;
    localparam logic [7:0] CMD_REGION_WIPE = 8'h36;
    localparam logic [7:0] CMD_CHIP_WIPE = 8'h37;

    // ****************************************
    // Framing, layout and reset values
    // ****************************************
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] ADDR_LAST = 2'h2;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [4:0] PIN_SYNC_RST = 5'h1f;
    localparam int PROT_W = 3;
    localparam int ADDR_W = 24;
    localparam int BUF_W = 32;
    localparam int BUF_DEPTH = 2;
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_PROT = 2;
    localparam logic [PROT_W-1:0] PROT_RST = 3'h0;

    typedef enum logic [1:0] {
        SFS_PH_OP,
        SFS_PH_ADDR,
        SFS_PH_DATA
    } sfs_phase_t;
endpackage : sfs_pkg

// ---- verilog/sfs_flash_spi.sv ----
// Contract
// R1: Output bit changes after clock falling edge
// R2: Input bits sampled on clock rising edge
// R3: Chip select high floats output, deselects
// R4: Standby only when no internal cycle
// R5: No instruction before first chip select fall
// R6: Hold pauses without losing bit position
// R7: During hold: output floats, inputs ignored
// R8: Host holds only while chip selected
// R9: Write protect freezes protect size bits
// R10: Clock idle low or high both work
// R11: Write enable then program starts cycle
// R12: At most 256 bytes, within one page
// R13: Host should program bytes in one burst
// R14: Wipe instructions start erase to all ones
// R15: Wipe needs write enable just before
// R16: Busy flag while internal cycle runs
// R17: Write enable latch cleared after writes
// R18: Hold changes only while clock low
// R19: Bytes move most significant bit first
module sfs_flash_spi (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic miso,
    output logic miso_oe_n,
    input wire logic [7:0] tx_data,
    output logic tx_take,
    output logic [sfs_pkg::BUF_W-1:0] prog_word,
    output logic prog_valid,
    input wire logic prog_ready,
    output logic prog_overrun,
    output logic prog_commit,
    output logic wipe_start,
    output logic wipe_all,
    output logic [sfs_pkg::ADDR_W-1:0] wipe_addr,
    output logic [7:0] wipe_fill,
    input wire logic cycle_done,
    output logic busy_flag,
    output logic write_enable_latch,
    output logic [sfs_pkg::PROT_W-1:0] protect_size_bits,
    output logic standby
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [4:0] pin_s1_q, pin_s2_q;
    logic sck_s3_q, cs_s3_q;

    // Pins reset high, so a chip select held low at power-up reads as a fall
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_s1_q <= sfs_pkg::PIN_SYNC_RST;
            pin_s2_q <= sfs_pkg::PIN_SYNC_RST;
            sck_s3_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            pin_s1_q <= {wp_n, hold_n, mosi, cs_n, sclk};
            pin_s2_q <= pin_s1_q;
            sck_s3_q <= pin_s2_q[0];
            cs_s3_q <= pin_s2_q[1];
        end
    end

    // ****************************************
    // Edge decode
    // ****************************************
    logic sck, csn, din, hold_pin, wp_pin;
    logic armed_q, hold_q, sel, rise, fall, cs_fall, cs_rise;
    logic busy_q, wel_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q, op_q, arg_q, byte_in, cmd_now;
    logic byte_done, push;
    // Data count stops here, so bytes past one page are dropped
    localparam logic [8:0] PAGE_END = sfs_pkg::PAGE_BYTES;
    sfs_pkg::sfs_phase_t phase_q;

    assign sck = pin_s2_q[0];
    assign csn = pin_s2_q[1];
    assign din = pin_s2_q[2];
    assign hold_pin = pin_s2_q[3];
    assign wp_pin = pin_s2_q[4];
    // Both clock polarities reduce to the same edges
    assign sel = !csn && armed_q; // [R3] [R5] [R10]
    assign rise = sel && !hold_q && sck && !sck_s3_q; // [R2] [R7]
    assign fall = sel && !hold_q && !sck && sck_s3_q; // [R1] [R7]
    assign cs_fall = !csn && cs_s3_q;
    assign cs_rise = csn && !cs_s3_q;
    assign byte_in = {sh_q[6:0], din}; // [R19]
    assign byte_done = rise && bit_q == sfs_pkg::BIT_LAST;
    assign cmd_now = (phase_q == sfs_pkg::SFS_PH_OP) ? byte_in : op_q;

    // Arm on first chip select fall after reset
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            armed_q <= 1'b0;
        end else if (cs_fall) begin
            armed_q <= 1'b1; // [R5]
        end
    end

    // Hold enters only while the clock is low, and leaves then or at deselect
    always_ff @(posedge ref_clk) begin
        if (!rstn || csn) begin
            hold_q <= 1'b0;
        end else if (!sck) begin
            hold_q <= !hold_pin; // [R18] [R8]
        end
    end

    // ****************************************
    // Receive framing
    // ****************************************
    logic [1:0] abyte_q;
    logic [sfs_pkg::ADDR_W-1:0] addr_q;
    logic [8:0] dcnt_q;
    logic needs_addr;

    assign needs_addr = cmd_now == sfs_pkg::CMD_PAGE_PROGRAM ||
        cmd_now == sfs_pkg::CMD_REGION_WIPE;

    // Bit count survives hold, so the pause loses no position
    always_ff @(posedge ref_clk) begin
        if (!rstn || cs_fall) begin
            bit_q <= '0;
            sh_q <= '0;
            phase_q <= sfs_pkg::SFS_PH_OP;
            abyte_q <= '0;
            dcnt_q <= '0;
        end else if (rise) begin
            sh_q <= byte_in; // [R2]
            bit_q <= bit_q + 3'h1; // [R6]
            if (byte_done) begin
                unique case (phase_q)
                    sfs_pkg::SFS_PH_OP: begin
                        phase_q <= needs_addr ? sfs_pkg::SFS_PH_ADDR
                                              : sfs_pkg::SFS_PH_DATA;
                    end
                    sfs_pkg::SFS_PH_ADDR: begin
                        abyte_q <= abyte_q + 2'h1;
                        if (abyte_q == sfs_pkg::ADDR_LAST) begin
                            phase_q <= sfs_pkg::SFS_PH_DATA;
                        end
                    end
                    sfs_pkg::SFS_PH_DATA: begin
                        if (dcnt_q != PAGE_END) begin
                            dcnt_q <= dcnt_q + 9'h1;
                        end
                    end
                endcase
            end
        end
    end

    // Opcode, address and argument capture; address wraps in page
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            op_q <= '0;
            arg_q <= '0;
            addr_q <= '0;
        end else if (byte_done) begin
            unique case (phase_q)
                sfs_pkg::SFS_PH_OP: op_q <= byte_in;
                sfs_pkg::SFS_PH_ADDR: addr_q <= {addr_q[15:0], byte_in};
                sfs_pkg::SFS_PH_DATA: begin
                    arg_q <= byte_in;
                    if (push) begin
                        addr_q[7:0] <= addr_q[7:0] + 8'h1; // [R12]
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Two-entry program data buffer
    // ****************************************
    logic [sfs_pkg::BUF_W-1:0] buf_q [sfs_pkg::BUF_DEPTH];
    logic wr_q, rd_q;
    logic [1:0] cnt_q;
    logic pop, buf_full, ovr_q;

    assign buf_full = cnt_q == 2'(sfs_pkg::BUF_DEPTH);
    // Beyond one page or while busy, data bytes are dropped
    assign push = byte_done && phase_q == sfs_pkg::SFS_PH_DATA &&
        op_q == sfs_pkg::CMD_PAGE_PROGRAM && wel_q && !busy_q &&
        dcnt_q != PAGE_END && !buf_full; // [R12]
    assign pop = prog_valid && prog_ready;
    assign prog_valid = cnt_q != 2'h0;
    assign prog_word = buf_q[rd_q];
    assign prog_overrun = ovr_q;

    // A full buffer cannot stall the host, so loss is flagged
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= '0;
            ovr_q <= 1'b0;
        end else begin
            if (push) begin
                buf_q[wr_q] <= {addr_q, byte_in};
                wr_q <= !wr_q;
            end
            if (pop) begin
                rd_q <= !rd_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
            if (byte_done && buf_full && op_q ==
                    sfs_pkg::CMD_PAGE_PROGRAM) begin
                ovr_q <= 1'b1;
            end else if (cs_fall) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Execution at chip select rise
    // ****************************************
    logic exec, is_write_enable_cmd, is_wrdi, do_status_write_cmd, do_pp, do_se, do_be, start;
    logic [sfs_pkg::PROT_W-1:0] prot_q;

    // Whole bytes only; a hold at deselect resets instead
    assign exec = cs_rise && armed_q && !hold_q && bit_q == '0 &&
        phase_q == sfs_pkg::SFS_PH_DATA;
    assign is_write_enable_cmd = exec && op_q == sfs_pkg::CMD_WRITE_ENABLE;
    assign is_wrdi = exec && op_q == sfs_pkg::CMD_WRITE_DISABLE;
    assign do_status_write_cmd = exec && wel_q && !busy_q && dcnt_q != '0 &&
        op_q == sfs_pkg::CMD_STATUS_WRITE;
    assign do_pp = exec && wel_q && !busy_q && dcnt_q != '0 &&
        op_q == sfs_pkg::CMD_PAGE_PROGRAM; // [R11]
    assign do_se = exec && wel_q && !busy_q &&
        op_q == sfs_pkg::CMD_REGION_WIPE; // [R15]
    assign do_be = exec && wel_q && !busy_q && prot_q == '0 &&
        op_q == sfs_pkg::CMD_CHIP_WIPE; // [R15]
    assign start = do_status_write_cmd || do_pp || do_se || do_be;

    // Latch, busy and protection; a new start wins over done
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wel_q <= 1'b0; // [R17]
            busy_q <= 1'b0;
            prot_q <= sfs_pkg::PROT_RST;
        end else begin
            if (is_write_enable_cmd && !busy_q) begin
                wel_q <= 1'b1;
            end else if (is_wrdi || start) begin
                wel_q <= 1'b0; // [R17]
            end
            busy_q <= start || (busy_q && !cycle_done); // [R16] [R4]
            if (do_status_write_cmd && wp_pin) begin
                prot_q <= arg_q[sfs_pkg::ST_PROT +: sfs_pkg::PROT_W]; // [R9]
            end
        end
    end

    // Pulses to the array logic
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prog_commit <= 1'b0;
            wipe_start <= 1'b0;
            wipe_all <= 1'b0;
            wipe_addr <= '0;
        end else begin
            prog_commit <= do_pp; // [R11]
            wipe_start <= do_se || do_be; // [R14]
            if (do_se || do_be) begin
                wipe_all <= do_be;
                wipe_addr <= addr_q;
            end
        end
    end

    assign wipe_fill = sfs_pkg::ERASED_BYTE; // [R14]
    assign busy_flag = busy_q;
    assign write_enable_latch = wel_q;
    assign protect_size_bits = prot_q;
    assign standby = csn && !busy_q; // [R4]

    // ****************************************
    // Transmit path
    // ****************************************
    logic [7:0] tx_sh_q, status;

    always_comb begin
        status = '0;
        status[sfs_pkg::ST_BUSY] = busy_q;
        status[sfs_pkg::ST_WEL] = wel_q;
        status[sfs_pkg::ST_PROT +: sfs_pkg::PROT_W] = prot_q;
    end

    // Load at byte end, launch each bit on the falling edge
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tx_sh_q <= '0;
            tx_take <= 1'b0;
            miso <= 1'b0;
            miso_oe_n <= 1'b1;
        end else begin
            tx_take <= 1'b0;
            if (byte_done) begin
                if (cmd_now == sfs_pkg::CMD_STATUS_READ) begin
                    tx_sh_q <= status; // [R16]
                end else begin
                    tx_sh_q <= tx_data;
                    tx_take <= 1'b1;
                end
            end else if (fall) begin
                miso <= tx_sh_q[7]; // [R1] [R19]
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
            miso_oe_n <= !(sel && !hold_q); // [R3] [R7]
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_deselect;
        csn ##1 csn;
    endsequence

    property p_float_cs;
        @(posedge ref_clk) disable iff (!rstn)
            s_deselect |-> miso_oe_n;
    endproperty
    a_float_cs: assert property (p_float_cs) // [R3]
        else $error("output driven while deselected");

    property p_float_hold;
        @(posedge ref_clk) disable iff (!rstn)
            hold_q |=> miso_oe_n;
    endproperty
    a_float_hold: assert property (p_float_hold) // [R7]
        else $error("output driven during hold");

    property p_miso_fall;
        @(posedge ref_clk) disable iff (!rstn)
            !$stable(miso) |-> $past(fall);
    endproperty
    a_miso_fall: assert property (p_miso_fall) // [R1]
        else $error("output changed without falling edge");

    property p_hold_keeps;
        @(posedge ref_clk) disable iff (!rstn)
            hold_q && !cs_fall |=> $stable(bit_q);
    endproperty
    a_hold_keeps: assert property (p_hold_keeps) // [R6]
        else $error("bit position moved in hold");

    property p_armed;
        @(posedge ref_clk) disable iff (!rstn)
            !armed_q |-> !rise && bit_q == '0;
    endproperty
    a_armed: assert property (p_armed) // [R5]
        else $error("bits taken before first select");

    sequence s_start;
        start ##1 busy_q;
    endsequence

    property p_start;
        @(posedge ref_clk) disable iff (!rstn)
            start |-> s_start ##0 !wel_q;
    endproperty
    a_start: assert property (p_start) // [R16] [R17]
        else $error("cycle start without busy or latch clear");

    property p_protect;
        @(posedge ref_clk) disable iff (!rstn)
            !wp_pin |=> $stable(prot_q);
    endproperty
    a_protect: assert property (p_protect) // [R9]
        else $error("protect bits changed while frozen");

    property p_page;
        @(posedge ref_clk) disable iff (!rstn)
            push |=> $past(addr_q[23:8]) == addr_q[23:8];
    endproperty
    a_page: assert property (p_page) // [R12]
        else $error("program address left page");

    property p_standby;
        @(posedge ref_clk) disable iff (!rstn)
            busy_q |-> !standby;
    endproperty
    a_standby: assert property (p_standby) // [R4]
        else $error("standby during internal cycle");
endmodule : sfs_flash_spi

// ---- tb/sfs_host_model.sv ----
module sfs_host_model (
    input wire logic ref_clk,
    input wire logic miso,
    input wire logic miso_oe_n,
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    output logic hold_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Host pin state
    // ****************************************
    logic cpol = 1'h0;
    logic hold_float = 1'h1;
    logic last_q = 1'h0;
    logic line;

    // No pull on the line: a released pin reads inverted, not stale
    assign line = miso_oe_n ? ~last_q : miso;
    always @(negedge ref_clk) begin
        if (!miso_oe_n) begin
            last_q <= miso;
        end
    end

    // Start deselected so the first select is a real fall
    initial begin
        sclk = 1'h0;
        cs_n = 1'h1;
        mosi = 1'h0;
        hold_n = 1'h1;
    end

    // ****************************************
    // Bus tasks, all moves on falling reference edges
    // ****************************************
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_n

    // Idle level only changes while deselected
    task automatic set_mode(input logic pol);
        cpol = pol;
        sclk <= pol;
        wait_n(4);
    endtask : set_mode

    // Frame opens on a chip select fall
    task automatic select();
        cs_n <= 1'h0;
        wait_n(4);
    endtask : select

    // Frame closes on a rise; data line no longer held
    task automatic deselect();
        cs_n <= 1'h1;
        mosi <= ~mosi;
        wait_n(10);
    endtask : deselect

    // Hold only while selected and clock low, junk meanwhile
    task automatic pause(input logic b);
        hold_n <= 1'h0;
        wait_n(6);
        repeat (2) begin
            sclk <= 1'h1;
            mosi <= ~b;
            wait_n(4);
            hold_float = hold_float & miso_oe_n;
            sclk <= 1'h0;
            wait_n(4);
        end
        mosi <= b;
        hold_n <= 1'h1;
        wait_n(6);
    endtask : pause

    // MSB first; read late in the high phase, since launch lags
    task automatic xfer(input logic [7:0] d, input int hold_at,
                        output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            sclk <= 1'h0;
            mosi <= d[i];
            wait_n(4);
            if (i == hold_at) begin
                pause(d[i]);
            end
            sclk <= 1'h1;
            wait_n(4);
            r[i] = line;
        end
        if (!cpol) begin
            sclk <= 1'h0;
        end
        wait_n(4);
    endtask : xfer
endmodule : sfs_host_model

// ---- tb/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Pins, design and host
    // ****************************************
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic wp_n = 1'h1;
    logic prog_ready = 1'h1;
    logic cycle_done = 1'h0;
    logic [7:0] tx_data = 8'h5a;
    logic sclk, cs_n, mosi, hold_n, miso, miso_oe_n, tx_take;
    logic prog_valid, prog_overrun, prog_commit, wipe_start, wipe_all;
    logic busy_flag, write_enable_latch, standby;
    logic [sfs_pkg::BUF_W-1:0] prog_word;
    logic [sfs_pkg::ADDR_W-1:0] wipe_addr;
    logic [sfs_pkg::PROT_W-1:0] protect_size_bits;
    logic [7:0] wipe_fill, rb;
    logic [31:0] words[$];
    int n_fail = 0;
    int samples_checked = 0;
    int n_commit = 0;
    int n_wipe = 0;

    // 25 MHz reference
    always #20 ref_clk = ~ref_clk;

    sfs_flash_spi dut_u (
        .ref_clk, .rstn, .sclk, .cs_n, .mosi, .hold_n, .wp_n, .miso,
        .miso_oe_n, .tx_data, .tx_take, .prog_word, .prog_valid,
        .prog_ready, .prog_overrun, .prog_commit, .wipe_start, .wipe_all,
        .wipe_addr, .wipe_fill, .cycle_done, .busy_flag,
        .write_enable_latch, .protect_size_bits, .standby
    );
    sfs_host_model host_u (
        .ref_clk, .miso, .miso_oe_n, .sclk, .cs_n, .mosi, .hold_n
    );

    // Pulses are short, so count them as they pass
    always @(posedge ref_clk) begin
        if (prog_commit === 1'h1) n_commit++;
        if (wipe_start === 1'h1) n_wipe++;
        if (prog_valid === 1'h1 && prog_ready === 1'h1) begin
            words.push_back(prog_word);
        end
    end

    // ****************************************
    // Compare, verdict and access tasks
    // ****************************************
    task automatic check_val(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_bit(input string what, input logic exp,
                             input logic got);
        check_val(what, {31'h0, exp}, {31'h0, got});
    endtask : check_bit

    task automatic results();
        $display("compares %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // One whole frame: opcode, then n tail bytes, optional hold
    task automatic frame(input logic [7:0] op, input int n,
                         input logic [47:0] tail, input int hold_at);
        host_u.select();
        host_u.xfer(op, -1, rb);
        for (int k = n - 1; k >= 0; k--) begin
            host_u.xfer(tail[k*8 +: 8], (k == 0) ? hold_at : -1, rb);
        end
        if (op == sfs_pkg::CMD_STATUS_READ) begin
            check_bit("drive", 1'h0, miso_oe_n);
        end
        host_u.deselect();
        check_bit("float", 1'h1, miso_oe_n);
    endtask : frame

    task automatic write_enable_cmd();
        frame(sfs_pkg::CMD_WRITE_ENABLE, 0, 48'h0, -1);
    endtask : write_enable_cmd

    task automatic stat(input logic [7:0] exp);
        frame(sfs_pkg::CMD_STATUS_READ, 1, 48'h0, -1);
        check_val("status", 32'(exp), 32'(rb));
    endtask : stat

    // Ends the internal cycle; busy drops one edge later
    task automatic done();
        cycle_done <= 1'h1;
        @(negedge ref_clk);
        cycle_done <= 1'h0;
        repeat (3) @(negedge ref_clk);
    endtask : done

    // Word arrival is bounded; a stuck buffer ends the run
    task automatic wait_words(input int n);
        int t;
        t = 0;
        while (words.size() < n && t < 400) begin
            @(negedge ref_clk);
            t++;
        end
        if (words.size() < n) begin
            n_fail++;
            results();
        end
    endtask : wait_words

    // Guard against a hang anywhere
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        results();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(negedge ref_clk);
        rstn = 1'h1;
        repeat (4) @(negedge ref_clk);
        stat(8'h00);
        write_enable_cmd();
        stat(8'h02);
        frame(sfs_pkg::CMD_WRITE_DISABLE, 0, 48'h0, -1);
        check_bit("wel", 1'h0, write_enable_latch);
        write_enable_cmd();
        frame(sfs_pkg::CMD_STATUS_WRITE, 1, 48'h0c, -1);
        check_val("prot", 32'h3, 32'(protect_size_bits));
        check_bit("wel", 1'h0, write_enable_latch);
        stat(8'h0d);
        check_bit("standby", 1'h0, standby);
        done();
        check_bit("busy", 1'h0, busy_flag);
        check_bit("standby", 1'h1, standby);
        wp_n = 1'h0;
        write_enable_cmd();
        frame(sfs_pkg::CMD_STATUS_WRITE, 1, 48'h00, -1);
        check_val("frozen", 32'h3, 32'(protect_size_bits));
        wp_n = 1'h1;
        done();
        write_enable_cmd();
        frame(sfs_pkg::CMD_CHIP_WIPE, 0, 48'h0, -1);
        check_val("wipe", 32'h0, 32'(n_wipe));
        write_enable_cmd();
        frame(sfs_pkg::CMD_STATUS_WRITE, 1, 48'h00, -1);
        done();
        frame(sfs_pkg::CMD_REGION_WIPE, 3, 48'h0a0b0c, -1);
        check_val("no write_enable_cmd", 32'h0, 32'(n_wipe));
        write_enable_cmd();
        frame(sfs_pkg::CMD_REGION_WIPE, 3, 48'h0a0b0c, -1);
        check_val("wipes", 32'h1, 32'(n_wipe));
        check_bit("all", 1'h0, wipe_all);
        check_val("addr", 32'h0a0b0c, 32'(wipe_addr));
        check_bit("busy", 1'h1, busy_flag);
        done();
        write_enable_cmd();
        frame(sfs_pkg::CMD_CHIP_WIPE, 0, 48'h0, -1);
        check_val("wipes", 32'h2, 32'(n_wipe));
        check_bit("all", 1'h1, wipe_all);
        check_val("fill", 32'hff, 32'(wipe_fill));
        done();
        host_u.set_mode(1'h1);
        stat(8'h00);
        words.delete();
        write_enable_cmd();
        frame(sfs_pkg::CMD_PAGE_PROGRAM, 6, 48'h0001fe_a0a1a2, 3);
        wait_words(3);
        check_val("w0", 32'h0001fea0, words[0]);
        check_val("w1", 32'h0001ffa1, words[1]);
        check_val("w2", 32'h000100a2, words[2]);
        check_bit("hold float", 1'h1, host_u.hold_float);
        check_val("commits", 32'h1, 32'(n_commit));
        check_bit("wel", 1'h0, write_enable_latch);
        check_bit("busy", 1'h1, busy_flag);
        done();
        host_u.set_mode(1'h0);
        prog_ready = 1'h0;
        words.delete();
        write_enable_cmd();
        frame(sfs_pkg::CMD_PAGE_PROGRAM, 6, 48'h000200_b0b1b2, -1);
        check_bit("overrun", 1'h1, prog_overrun);
        prog_ready = 1'h1;
        wait_words(2);
        check_val("w0", 32'h000200b0, words[0]);
        check_val("w1", 32'h000201b1, words[1]);
        check_bit("empty", 1'h0, prog_valid);
        done();
        stat(8'h00);
        check_bit("overrun", 1'h0, prog_overrun);
        results();
    end
endmodule : testbench
